/* File: spf_framer.v */
// Chosen here: the address map and the APB slave port.
`include "spf_regs.vh"
`default_nettype none

module spf_framer #(
    parameter integer CYC_PER_MS = `SPF_TICK_CYC
) (
    input  wire        clk_sys,
    input  wire        rst,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata_q,
    output reg         pready_q,
    output reg         pslverr_q,
    // byte stream from the uart receiver
    input  wire        rx_valid,
    input  wire [7:0]  rx_data,
    output reg         rx_ready_q,
    // frame stream to the network transmit path
    output reg         tx_valid_q,
    output reg  [7:0]  tx_data_q,
    output reg         tx_last_q,
    input  wire        tx_ready
);
    // ****************************************************************
    // constants
    // ****************************************************************
    localparam [1:0] S_COLLECT = 2'h0;
    localparam [1:0] S_RD      = 2'h1;
    localparam [1:0] S_LD      = 2'h2;
    localparam [1:0] S_SEND    = 2'h3;

    localparam [`SPF_CNT_W-1:0] CNT_ONE  = 1;
    localparam [`SPF_CNT_W-1:0] CNT_ZERO = 0;
    localparam [15:0]           IDLE_MAX = 16'hffff;
    localparam [15:0]           ONE16    = 16'h0001;

    // ****************************************************************
    // configuration and state
    // ****************************************************************
    reg                    d1_en_q;
    reg                    d2_en_q;
    reg  [1:0]             mode_q;
    reg  [7:0]             d1_q;
    reg  [7:0]             d2_q;
    reg  [`SPF_CNT_W-1:0]  plen_q;
    reg  [15:0]            flush_q;

    reg  [1:0]             state_q;
    reg  [`SPF_CNT_W-1:0]  cnt_q;
    reg  [`SPF_CNT_W-1:0]  idx_q;
    reg                    prev_d1_q;
    reg  [1:0]             post_q;
    reg  [15:0]            idle_q;
    reg  [15:0]            frames_q;

    wire                   tick;
    wire [7:0]             rd_data;

    reg                    wr_en;
    reg  [`SPF_CNT_W-1:0]  cnt_d;
    reg  [1:0]             post_d;
    reg                    rel;

    wire take;
    wire hit_one;
    wire hit_two;
    wire hit;
    wire timeout;

    // ****************************************************************
    // delimiter match
    // ****************************************************************
    assign take    = rx_valid && rx_ready_q;
    assign hit_one = d1_en_q && !d2_en_q && (rx_data == d1_q);
    // a lone second delimiter never matches, framing then rests on length and timeout
    assign hit_two = d1_en_q && d2_en_q && prev_d1_q && (rx_data == d2_q);
    // no new delimiter is looked for while trailing bytes are still owed
    assign hit     = (post_q == 2'h0) && (hit_one || hit_two);

    // ****************************************************************
    // idle flush
    // ****************************************************************
    assign timeout = (flush_q != 16'h0000) && (cnt_q != CNT_ZERO) &&
                     (idle_q >= flush_q) && (state_q == S_COLLECT);

    spf_ms_tick #(
        .CYC     (CYC_PER_MS)
    ) u_tick (
        .clk_sys (clk_sys),
        .rst     (rst),
        .restart (take),
        .tick_q  (tick)
    );

    // ****************************************************************
    // release decision for the byte in hand
    // ****************************************************************
    always @* begin
        wr_en  = 1'b0;
        cnt_d  = cnt_q;
        post_d = post_q;
        rel    = 1'b0;
        if (take) begin
            if (hit && (mode_q == `SPF_MODE_STRIP)) begin
                // the first character of a pair is already stored, take it back
                cnt_d = hit_two ? (cnt_q - CNT_ONE) : cnt_q;
                rel   = 1'b1;
            end else begin
                wr_en = 1'b1;
                cnt_d = cnt_q + CNT_ONE;
                if (hit) begin
                    if (mode_q == `SPF_MODE_PLUS1) begin
                        post_d = 2'h1;
                    end else if (mode_q == `SPF_MODE_PLUS2) begin
                        post_d = 2'h2;
                    end else begin
                        rel = 1'b1;
                    end
                end else if (post_q != 2'h0) begin
                    post_d = post_q - 2'h1;
                    if (post_q == 2'h1) begin
                        rel = 1'b1;
                    end
                end
                if (cnt_d == `SPF_BUF_BYTES) begin
                    rel = 1'b1;
                end
                if ((plen_q != CNT_ZERO) && (cnt_d == plen_q)) begin
                    rel = 1'b1;
                end
            end
        end else if (timeout) begin
            rel = 1'b1;
        end
        if (rel) begin
            post_d = 2'h0;
        end
    end

    // ****************************************************************
    // packing buffer
    // ****************************************************************
    spf_mem #(
        .DW        (8),
        .AW        (`SPF_ADDR_W)
    ) u_buf (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .wr_en     (wr_en),
        .wr_addr   (cnt_q[`SPF_ADDR_W-1:0]),
        .wr_data   (rx_data),
        .rd_addr   (idx_q[`SPF_ADDR_W-1:0]),
        .rd_data_q (rd_data)
    );

    // ****************************************************************
    // collect and drain
    // ****************************************************************
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q    <= S_COLLECT;
            cnt_q      <= CNT_ZERO;
            idx_q      <= CNT_ZERO;
            prev_d1_q  <= 1'b0;
            post_q     <= 2'h0;
            idle_q     <= 16'h0000;
            frames_q   <= 16'h0000;
            rx_ready_q <= 1'b1;
            tx_valid_q <= 1'b0;
            tx_data_q  <= 8'h00;
            tx_last_q  <= 1'b0;
        end else begin
            case (state_q)
                S_COLLECT: begin
                    post_q <= post_d;
                    if (take) begin
                        prev_d1_q <= (rx_data == d1_q) && !rel;
                        idle_q    <= 16'h0000;
                    end else if (tick && (idle_q != IDLE_MAX)) begin
                        idle_q <= idle_q + ONE16;
                    end
                    if (rel) begin
                        prev_d1_q <= 1'b0;
                        idle_q    <= 16'h0000;
                        if (cnt_d == CNT_ZERO) begin
                            // a stripped lone delimiter leaves nothing to send
                            cnt_q <= CNT_ZERO;
                        end else begin
                            cnt_q      <= cnt_d;
                            idx_q      <= CNT_ZERO;
                            rx_ready_q <= 1'b0;
                            state_q    <= S_RD;
                        end
                    end else begin
                        cnt_q <= cnt_d;
                    end
                end
                S_RD: begin
                    state_q <= S_LD;
                end
                S_LD: begin
                    tx_data_q  <= rd_data;
                    tx_valid_q <= 1'b1;
                    tx_last_q  <= (idx_q == (cnt_q - CNT_ONE));
                    state_q    <= S_SEND;
                end
                S_SEND: begin
                    if (tx_ready) begin
                        tx_valid_q <= 1'b0;
                        tx_last_q  <= 1'b0;
                        if (tx_last_q) begin
                            // buffer cleared only after the whole frame is taken
                            cnt_q      <= CNT_ZERO;
                            frames_q   <= frames_q + ONE16;
                            rx_ready_q <= 1'b1;
                            state_q    <= S_COLLECT;
                        end else begin
                            idx_q   <= idx_q + CNT_ONE;
                            state_q <= S_RD;
                        end
                    end
                end
                default: begin
                    state_q <= S_COLLECT;
                end
            endcase
        end
    end

    // ****************************************************************
    // apb slave
    // ****************************************************************
    // one access cycle: pready rises in the cycle after setup
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= psel && !penable;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
            if (psel && !penable) begin
                if (paddr == `SPF_OFF_CTRL) begin
                    prdata_q[`SPF_CTRL_D1EN] <= d1_en_q;
                    prdata_q[`SPF_CTRL_D2EN] <= d2_en_q;
                    prdata_q[`SPF_CTRL_MODE_MSB:`SPF_CTRL_MODE_LSB] <= mode_q;
                end else if (paddr == `SPF_OFF_DELIM) begin
                    prdata_q[`SPF_DELIM_D1_MSB:`SPF_DELIM_D1_LSB] <= d1_q;
                    prdata_q[`SPF_DELIM_D2_MSB:`SPF_DELIM_D2_LSB] <= d2_q;
                end else if (paddr == `SPF_OFF_PKTLEN) begin
                    prdata_q[`SPF_CNT_W-1:0] <= plen_q;
                end else if (paddr == `SPF_OFF_FLUSH) begin
                    prdata_q[15:0] <= flush_q;
                end else if (paddr == `SPF_OFF_STATUS) begin
                    prdata_q[`SPF_STAT_CNT_MSB:0] <= cnt_q;
                    prdata_q[`SPF_STAT_BUSY]      <= (state_q != S_COLLECT);
                    prdata_q[`SPF_STAT_POST_MSB:`SPF_STAT_POST_LSB] <= post_q;
                end else if (paddr == `SPF_OFF_FRAMES) begin
                    prdata_q[15:0] <= frames_q;
                end else begin
                    pslverr_q <= 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            d1_en_q <= 1'b0;
            d2_en_q <= 1'b0;
            mode_q  <= `SPF_RST_MODE;
            d1_q    <= `SPF_RST_DELIM;
            d2_q    <= `SPF_RST_DELIM;
            plen_q  <= `SPF_RST_PKTLEN;
            flush_q <= `SPF_RST_FLUSH;
        end else if (psel && penable && pready_q && pwrite) begin
            if (paddr == `SPF_OFF_CTRL) begin
                d1_en_q <= pwdata[`SPF_CTRL_D1EN];
                d2_en_q <= pwdata[`SPF_CTRL_D2EN];
                mode_q  <= pwdata[`SPF_CTRL_MODE_MSB:`SPF_CTRL_MODE_LSB];
            end else if (paddr == `SPF_OFF_DELIM) begin
                d1_q <= pwdata[`SPF_DELIM_D1_MSB:`SPF_DELIM_D1_LSB];
                d2_q <= pwdata[`SPF_DELIM_D2_MSB:`SPF_DELIM_D2_LSB];
            end else if (paddr == `SPF_OFF_PKTLEN) begin
                plen_q <= pwdata[`SPF_CNT_W-1:0];
            end else if (paddr == `SPF_OFF_FLUSH) begin
                // values under 10 ms are accepted; choosing a sane one is software's job
                flush_q <= pwdata[15:0];
            end
        end
    end
endmodule // spf_framer

`default_nettype wire

/* File: spf_regs.vh */
`ifndef SPF_REGS_VH
`define SPF_REGS_VH

// ****************************************************************
// register offsets (byte addresses on the apb bus)
// ****************************************************************
`define SPF_OFF_CTRL        12'h000
`define SPF_OFF_DELIM       12'h004
`define SPF_OFF_PKTLEN      12'h008
`define SPF_OFF_FLUSH       12'h00c
`define SPF_OFF_STATUS      12'h010
`define SPF_OFF_FRAMES      12'h014

// ****************************************************************
// field positions
// ****************************************************************
`define SPF_CTRL_D1EN       0
`define SPF_CTRL_D2EN       1
`define SPF_CTRL_MODE_LSB   2
`define SPF_CTRL_MODE_MSB   3
`define SPF_DELIM_D1_LSB    0
`define SPF_DELIM_D1_MSB    7
`define SPF_DELIM_D2_LSB    8
`define SPF_DELIM_D2_MSB    15
`define SPF_STAT_CNT_MSB    10
`define SPF_STAT_BUSY       16
`define SPF_STAT_POST_LSB   18
`define SPF_STAT_POST_MSB   19

// ****************************************************************
// post-delimiter handling choices
// ****************************************************************
`define SPF_MODE_PLAIN      2'h0
`define SPF_MODE_PLUS1      2'h1
`define SPF_MODE_PLUS2      2'h2
`define SPF_MODE_STRIP      2'h3

// ****************************************************************
// reset values and sizes
// ****************************************************************
`define SPF_RST_MODE        2'h0
`define SPF_RST_DELIM       8'h00
`define SPF_RST_PKTLEN      11'h000
`define SPF_RST_FLUSH       16'h0000
`define SPF_BUF_BYTES       11'h400
`define SPF_CNT_W           11
`define SPF_ADDR_W          10

// ****************************************************************
// timing
// ****************************************************************
`define SPF_CLK_HZ          20000000
`define SPF_TICK_MS         1
`define SPF_TICK_CYC        ((`SPF_CLK_HZ / 1000) * `SPF_TICK_MS)

`endif

/* File: spf_mem.v */
`default_nettype none

// ****************************************************************
// packing buffer storage, registered read
// ****************************************************************
module spf_mem #(
    parameter integer DW = 8,
    parameter integer AW = 10
) (
    input  wire          clk_sys,
    input  wire          rst,
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data,
    input  wire [AW-1:0] rd_addr,
    output reg  [DW-1:0] rd_data_q
);
    reg [DW-1:0] mem_q [0:(1<<AW)-1];

    // no reset on the array so it maps onto block ram
    always @(posedge clk_sys) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_data_q <= {DW{1'b0}};
        end else begin
            rd_data_q <= mem_q[rd_addr];
        end
    end
endmodule // spf_mem

`default_nettype wire

/* File: spf_ms_tick.v */
`include "spf_regs.vh"
`default_nettype none

// ****************************************************************
// millisecond tick, re-phased by restart
// ****************************************************************
module spf_ms_tick #(
    parameter integer CYC = `SPF_TICK_CYC
) (
    input  wire clk_sys,
    input  wire rst,
    input  wire restart,
    output reg  tick_q
);
    localparam integer W = $clog2(CYC + 1);
    localparam [W-1:0] ONE  = {{(W-1){1'b0}}, 1'b1};
    localparam [W-1:0] LAST = CYC[W-1:0] - ONE;

    reg [W-1:0] cnt_q;

    // restart keeps the idle interval measured from the last byte exactly
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q  <= {W{1'b0}};
            tick_q <= 1'b0;
        end else if (restart) begin
            cnt_q  <= {W{1'b0}};
            tick_q <= 1'b0;
        end else if (cnt_q == LAST) begin
            cnt_q  <= {W{1'b0}};
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + ONE;
            tick_q <= 1'b0;
        end
    end
endmodule // spf_ms_tick

`default_nettype wire

/* File: spf_framer_asserts.sv */
`include "spf_regs.vh"
`default_nettype none
// ****
// port checks of the framer
// ****
module spf_framer_asserts #(
    parameter integer CYC_PER_MS = 20000
) (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata_q,
    input wire logic        pready_q,
    input wire logic        pslverr_q,
    input wire logic        rx_valid,
    input wire logic [7:0]  rx_data,
    input wire logic        rx_ready_q,
    input wire logic        tx_valid_q,
    input wire logic [7:0]  tx_data_q,
    input wire logic        tx_last_q,
    input wire logic        tx_ready
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [31:0] ctrl_q;
    logic [31:0] delim_q;
    logic [10:0] plen_q;
    logic [10:0] cnt_q;
    logic [1:0]  owe_q;
    wire         acc  = rx_valid && rx_ready_q;
    wire  [1:0]  mode = ctrl_q[3:2];
    wire         hit  = acc && ctrl_q[0] && !ctrl_q[1] && rx_data == delim_q[7:0];
    wire         plus = mode == `SPF_MODE_PLUS1 || mode == `SPF_MODE_PLUS2;
    // shadow of the configuration as written over apb
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_q <= 32'h0;
            delim_q <= 32'h0;
            plen_q <= 11'h000;
        end else if (psel && penable && pready_q && pwrite) begin
            case (paddr)
                `SPF_OFF_CTRL:   ctrl_q <= pwdata;
                `SPF_OFF_DELIM:  delim_q <= pwdata;
                `SPF_OFF_PKTLEN: plen_q <= pwdata[10:0];
                default: ;
            endcase
        end
    end
    // accepted bytes and owed trailers; a drain empties the buffer
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst || !rx_ready_q) begin
            cnt_q <= 11'h000;
            owe_q <= 2'h0;
        end else if (acc) begin
            cnt_q <= cnt_q + 11'h001;
            if (owe_q != 2'h0)
                owe_q <= owe_q - 2'h1;
            else if (hit && plus)
                owe_q <= mode;
        end
    end
    sequence s_drain;
        !rx_ready_q ##[1:3] tx_valid_q;
    endsequence
    AST_APB_READY: assert property (psel && !penable |=> pready_q)
        else $error("no ready after setup");
    AST_APB_PULSE: assert property (pready_q |=> !pready_q)
        else $error("ready longer than one cycle");
    AST_TX_HOLD: assert property (tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_data_q) && $stable(tx_last_q))
        else $error("frame byte changed before taken");
    AST_DRAIN_BLOCK: assert property (tx_valid_q |-> !rx_ready_q)
        else $error("bytes accepted while draining");
    AST_PLAIN_REL: assert property (hit && mode == `SPF_MODE_PLAIN |=> s_drain)
        else $error("plain delimiter did not release");
    AST_PLUS_WAIT: assert property (hit && plus && owe_q == 2'h0 && cnt_q != 11'h3ff && cnt_q + 11'h001 != plen_q |=> rx_ready_q)
        else $error("released without trailing bytes");
    AST_PLUS_REL: assert property (acc && owe_q == 2'h1 |=> s_drain)
        else $error("last trailing byte did not release");
    AST_PKTLEN: assert property (acc && mode != `SPF_MODE_STRIP && plen_q != 11'h000 && cnt_q + 11'h001 == plen_q |=> s_drain)
        else $error("packet length reached without release");
    AST_FULL: assert property (acc && mode != `SPF_MODE_STRIP && cnt_q == 11'h3ff |=> s_drain)
        else $error("full buffer not released");
endmodule // spf_framer_asserts

bind spf_framer spf_framer_asserts #(.CYC_PER_MS(CYC_PER_MS)) u_spf_framer_asserts (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready_q(rx_ready_q),
    .tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q), .tx_last_q(tx_last_q), .tx_ready(tx_ready)
);
`default_nettype wire

/* File: spf_uart_src.sv */
`default_nettype none
// ****
// serial sender: queued bytes with an optional idle gap
// ****
module spf_uart_src (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       rx_ready_q,
    output var  logic       rx_valid,
    output var  logic [7:0] rx_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] q [$];
    int         gap = 0;
    int         wait_q = 0;
    task automatic push(input logic [7:0] b);
        q.push_back(b);
    endtask
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
            wait_q <= 0;
        end else if (rx_valid && !rx_ready_q) begin
            rx_valid <= 1'b1;
        end else if (wait_q != 0) begin
            // idle gap between characters; data not meaningful, so keep it moving
            rx_valid <= 1'b0;
            rx_data <= ~rx_data;
            wait_q <= wait_q - 1;
        end else if (q.size() != 0) begin
            rx_valid <= 1'b1;
            rx_data <= q.pop_front();
            wait_q <= gap;
        end else begin
            rx_valid <= 1'b0;
            rx_data <= ~rx_data;
        end
    end
endmodule // spf_uart_src
`default_nettype wire

/* File: tb.sv */
`include "spf_regs.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic [31:0] ctrl;
        logic [31:0] plen;
        int          n;
        int          m;
        logic [7:0]  b [6];
    } spf_row_t;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        tx_ready = 1'b0;
    wire  [31:0] prdata_q;
    wire         pready_q;
    wire         pslverr_q;
    wire         rx_valid;
    wire  [7:0]  rx_data;
    wire         rx_ready_q;
    wire         tx_valid_q;
    wire  [7:0]  tx_data_q;
    wire         tx_last_q;
    int          err_total = 0;
    int          total_checks = 0;
    int          cur = 0;
    int          cyc = 0;
    int          lens [$];
    logic [7:0]  got [$];
    logic [31:0] rd;
    logic        er;
    logic [7:0]  e6 [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05};
    // ctrl, pktlen, bytes sent, bytes expected (a prefix of those sent), bytes
    spf_row_t    rows [8] = '{
        '{32'h1, 32'h0, 3, 3, '{8'h11, 8'h22, 8'h0d, 8'h00, 8'h00, 8'h00}},
        '{32'h5, 32'h0, 3, 3, '{8'h11, 8'h0d, 8'h33, 8'h00, 8'h00, 8'h00}},
        '{32'h9, 32'h0, 3, 3, '{8'h0d, 8'h33, 8'h44, 8'h00, 8'h00, 8'h00}},
        '{32'hd, 32'h0, 3, 2, '{8'h11, 8'h22, 8'h0d, 8'h00, 8'h00, 8'h00}},
        '{32'h3, 32'h0, 5, 5, '{8'h11, 8'h0d, 8'h22, 8'h0d, 8'h0a, 8'h00}},
        '{32'hf, 32'h0, 3, 1, '{8'h11, 8'h0d, 8'h0a, 8'h00, 8'h00, 8'h00}},
        '{32'h0, 32'h3, 3, 3, '{8'h01, 8'h02, 8'h03, 8'h00, 8'h00, 8'h00}},
        '{32'h2, 32'h3, 3, 3, '{8'h0a, 8'h0a, 8'h05, 8'h00, 8'h00, 8'h00}}};
    spf_framer #(.CYC_PER_MS(20)) u_spf_framer (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
        .pslverr_q(pslverr_q), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready_q(rx_ready_q), .tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q),
        .tx_last_q(tx_last_q), .tx_ready(tx_ready));
    spf_uart_src u_spf_uart_src (.clk_sys(clk_sys), .rst(rst), .rx_ready_q(rx_ready_q),
        .rx_valid(rx_valid), .rx_data(rx_data));
    always #25 clk_sys = ~clk_sys;
    // network side stalls one cycle in three and collects frames
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        tx_ready <= (cyc % 3) != 1;
        if (tx_valid_q === 1'b1 && tx_ready) begin
            got.push_back(tx_data_q);
            cur = cur + 1;
            if (tx_last_q === 1'b1) begin
                lens.push_back(cur);
                cur = 0;
            end
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic hang(input string m);
        err_total++;
        $display("ERROR %0t timeout in %s", $time, m);
        results();
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready_q !== 1'b1 && n < 20);
        if (n >= 20)
            hang("apb");
        rd = prdata_q;
        er = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    // seq: expected bytes count up from zero instead of coming from e
    task automatic chk_frame(input logic [7:0] e [6], input int m, input bit seq);
        int n;
        n = 0;
        while (lens.size() == 0 && n < 20000) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 20000)
            hang("frame");
        chk(lens.pop_front(), m, "frame length");
        for (int k = 0; k < m; k++)
            chk(got.pop_front(), seq ? 8'(k) : e[k], "frame byte");
        repeat (12) @(posedge clk_sys);
        chk(lens.size(), 0, "extra frame");
    endtask
    task automatic feed(input int n, input int gap);
        u_spf_uart_src.gap = gap;
        for (int k = 0; k < n; k++)
            u_spf_uart_src.push(gap > 200 ? 8'h00 : 8'(k));
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk(rx_ready_q, 1'b1, "ready after reset");
        chk(tx_valid_q, 1'b0, "tx idle after reset");
        // ctrl, delim, pktlen and flush sit at consecutive words from zero
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, 12'(4 * k), 32'h0);
            chk(rd, 32'h0, "reset value");
        end
        apb(1'b0, 12'h018, 32'h0);
        chk({31'h0, er}, 32'h1, "unmapped error");
        $display("test reset done");
        apb(1'b1, `SPF_OFF_DELIM, 32'h0000_0a0d);
        foreach (rows[i]) begin
            apb(1'b1, `SPF_OFF_CTRL, rows[i].ctrl);
            apb(1'b1, `SPF_OFF_PKTLEN, rows[i].plen);
            for (int k = 0; k < rows[i].n; k++)
                u_spf_uart_src.push(rows[i].b[k]);
            chk_frame(rows[i].b, rows[i].m, 1'b0);
        end
        apb(1'b0, `SPF_OFF_FRAMES, 32'h0);
        chk(rd[15:0], 16'h0008, "frames sent");
        $display("test table done");
        apb(1'b1, `SPF_OFF_CTRL, 32'h0);
        apb(1'b1, `SPF_OFF_PKTLEN, 32'h0);
        feed(3, 0);
        repeat (200) @(posedge clk_sys);
        chk(lens.size(), 0, "flush while disabled");
        apb(1'b0, `SPF_OFF_STATUS, 32'h0);
        chk(rd[10:0], 11'h003, "buffered count");
        // timeout kept above 10 ms as software must; 11 ms is 220 cycles here
        apb(1'b1, `SPF_OFF_FLUSH, 32'hb);
        chk_frame(e6, 3, 1'b1);
        feed(4, 150);
        chk_frame(e6, 4, 1'b1);
        feed(2, 300);
        chk_frame(e6, 1, 1'b1);
        chk_frame(e6, 1, 1'b1);
        $display("test idle flush done");
        apb(1'b1, `SPF_OFF_FLUSH, 32'h0);
        feed(1030, 0);
        chk_frame(e6, 1024, 1'b1);
        apb(1'b1, `SPF_OFF_FLUSH, 32'hb);
        chk_frame(e6, 6, 1'b1);
        $display("test full buffer done");
        // reset in mid-run with bytes buffered and a timeout armed
        feed(2, 0);
        repeat (5) @(posedge clk_sys);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk(rx_ready_q, 1'b1, "ready after mid reset");
        apb(1'b0, `SPF_OFF_STATUS, 32'h0);
        chk(rd, 32'h0, "status after mid reset");
        apb(1'b0, `SPF_OFF_FLUSH, 32'h0);
        chk(rd, 32'h0, "flush after mid reset");
        repeat (300) @(posedge clk_sys);
        chk(lens.size(), 0, "frame after mid reset");
        $display("test mid reset done");
        results();
    end
endmodule // tb
`default_nettype wire
